// >>> hw/bdia_consts.svh
// constants for the beam dump interlock aggregator
`ifndef BDIA_CONSTS_SVH
`define BDIA_CONSTS_SVH
`define BDIA_CRATES 3
`define BDIA_CHANS 8
`define BDIA_NOTRIG_IDX 1
`define BDIA_AUTO_CRATE 1
`define BDIA_INJ_CRATE 2
`define BDIA_AUTO_MAX 2'h3
`define BDIA_WARM_DONE 2'h3
`define BDIA_ENERGY_THR_GEV 10'h064
`define BDIA_CLK_MHZ 10
`define BDIA_PREPULSE_DELAY_US 50
`define BDIA_PREPULSE_DELAY_CYC (`BDIA_PREPULSE_DELAY_US * `BDIA_CLK_MHZ)
`define BDIA_EV_EOC 0
`define BDIA_EV_CYCLE_END 1
`define BDIA_EV_DUMP 2
`define BDIA_EV_PREPULSE 3
`define BDIA_EV_NUM 4
`endif

// >>> hw/bdia_gap_sync.sv
// beam gap alignment of programmed dumps from the revolution reference
`timescale 1ns/1ps
module bdia_gap_sync (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_arm,
  input wire logic i_rev_ref,
  output logic o_fire
);
  typedef struct packed {
    logic [2:0] r;
    logic rf;
    logic rp;
    logic armed;
    logic fire;
  } bdia_gap_s;

  bdia_gap_s s_q;
  bdia_gap_s s_d;
  logic rev_rise;

  assign rev_rise = s_q.rf & ~s_q.rp;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.r = {s_q.r[1:0], i_rev_ref};
    if (s_q.r[1] == s_q.r[2]) begin
      s_d.rf = s_q.r[2];
    end
    s_d.rp = s_q.rf;
    s_d.armed = (s_q.armed & ~rev_rise) | i_arm;
    s_d.fire = s_q.armed & rev_rise;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_fire = s_q.fire;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_fire_on_gap: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_fire |-> $past(rev_rise) && $past(s_q.armed))
    else $error("programmed kick not on gap marker");

  a_armed_fires: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.armed && rev_rise) |=> o_fire)
    else $error("armed dump missed the gap");
endmodule

// >>> hw/bdia_pkg.sv
// types shared by the beam dump interlock aggregator
package bdia_pkg;
  typedef enum logic [0:0] {
    BDIA_PP_IDLE,
    BDIA_PP_DELAY
  } bdia_pp_e;
  typedef logic [9:0] bdia_energy_t;
endpackage

// >>> hw/bdia_top.sv
// beam dump interlock aggregator top level
//
// Contract
// - programmed dump fires from a timing event, kick aligned to the beam gap.
// - gap alignment comes from the revolution frequency reference input.
// - missing end-of-cycle trigger raises the no-trigger interlock, crate 1 channel 2.
// - any client interlock fires the dump at once, without gap alignment.
// - up to threshold energy use horizontal absorber, above it the vertical one.
// - client inputs form three crates of numbered channels, each fixed source.
// - crate 2 channels auto-reset at each elementary cycle end, timing triggered.
// - auto reset clears a channel only if its client signal is healthy again.
// - after three auto resets, further ones wait for a manual reset.
// - crate 3 summary goes to the upstream injector to stop extraction.
// - each channel has an operator disable; disabled channels never dump.
// - beam returns with a disabled channel only once software condition disabled.
// - experts protect channels from operator disable; remote flag shows permission.
// - summary of all emergency channels feeds the injection kicker crate.
// - emergency interlock delays injection pre-pulse by 50 us to injection dump.
// - resetting the dump system also clears the injection kicker interlock.
// - per channel, display ok state, remote flag and enabled state.
`timescale 1ns/1ps
`include "bdia_consts.svh"
module bdia_top #(
  parameter int CRATES = `BDIA_CRATES,
  parameter int CHANS = `BDIA_CHANS,
  parameter int NCH = CRATES * CHANS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [NCH-1:0] i_loop_ok,
  input wire logic i_eoc_trigger,
  input wire logic i_cycle_end,
  input wire logic i_dump_event,
  input wire logic i_inj_prepulse,
  input wire logic i_rev_ref,
  input wire logic [9:0] i_beam_energy_gev,
  input wire logic i_manual_reset,
  input wire logic [NCH-1:0] i_op_disable,
  input wire logic [NCH-1:0] i_expert_protect,
  input wire logic [NCH-1:0] i_sw_cond_disabled,
  output logic o_horizontal_dump_kicker,
  output logic o_vertical_dump_kicker,
  output logic o_emergency_dump,
  output logic o_injection_kicker_summary,
  output logic o_injection_inhibit,
  output logic o_inj_prepulse,
  output logic o_injector_extraction_stop,
  output logic o_beam_permit,
  output logic [NCH-1:0] o_chan_ok,
  output logic [NCH-1:0] o_chan_remote,
  output logic [NCH-1:0] o_chan_enabled,
  output logic [NCH-1:0] o_chan_disabled,
  output logic o_no_trigger,
  output logic [1:0] o_auto_count
);
  localparam logic [9:0] DLY_LOAD = 10'(`BDIA_PREPULSE_DELAY_CYC - 1);

  typedef struct packed {
    logic [NCH-1:0] l1;
    logic [NCH-1:0] l2;
    logic [NCH-1:0] l3;
    logic [NCH-1:0] lf;
    logic [`BDIA_EV_NUM-1:0] e1;
    logic [`BDIA_EV_NUM-1:0] e2;
    logic [`BDIA_EV_NUM-1:0] e3;
    logic [`BDIA_EV_NUM-1:0] ef;
    logic [`BDIA_EV_NUM-1:0] ep;
    logic [1:0] warm;
    logic [NCH-1:0] trip;
    logic [NCH-1:0] dis;
    logic [1:0] acnt;
    logic eoc_seen;
    logic no_trig;
    logic summ;
    logic c3;
    logic inh;
    bdia_pkg::bdia_pp_e pst;
    logic [9:0] dcnt;
    logic pp;
    logic kh;
    logic kv;
  } bdia_state_s;

  bdia_state_s s_q;
  bdia_state_s s_d;
  logic [`BDIA_EV_NUM-1:0] ev_rise;
  logic [NCH-1:0] fault;
  logic [NCH-1:0] en;
  logic [NCH-1:0] clr;
  logic prog_fire;
  logic fire_any;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [NCH-1:0] crate_mask(input int c);
    logic [NCH-1:0] m;
    m = '0;
    for (int k = 0; k < CHANS; k++) begin
      m[c * CHANS + k] = 1'b1;
    end
    return m;
  endfunction

  assign ev_rise = s_q.ef & ~s_q.ep;

  // ----------------------------------------
  // gap aligned programmed dump
  // ----------------------------------------
  bdia_gap_sync u_gap (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_arm(ev_rise[`BDIA_EV_DUMP]),
    .i_rev_ref(i_rev_ref),
    .o_fire(prog_fire)
  );

  // ----------------------------------------
  // channel fault and enable
  // ----------------------------------------
  always_comb begin
    fault = '0;
    if (s_q.warm == `BDIA_WARM_DONE) begin
      fault = ~s_q.lf;
    end
    fault[`BDIA_NOTRIG_IDX] = fault[`BDIA_NOTRIG_IDX] | (s_q.no_trig & ~i_manual_reset);
  end

  assign en = ~(i_op_disable & ~i_expert_protect);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    clr = '0;
    fire_any = 1'b0;
    s_d.l1 = i_loop_ok;
    s_d.l2 = s_q.l1;
    s_d.l3 = s_q.l2;
    for (int k = 0; k < NCH; k++) begin
      if (s_q.l2[k] == s_q.l3[k]) begin
        s_d.lf[k] = s_q.l3[k];
      end
    end
    s_d.e1 = {i_inj_prepulse, i_dump_event, i_cycle_end, i_eoc_trigger};
    s_d.e2 = s_q.e1;
    s_d.e3 = s_q.e2;
    for (int k = 0; k < `BDIA_EV_NUM; k++) begin
      if (s_q.e2[k] == s_q.e3[k]) begin
        s_d.ef[k] = s_q.e3[k];
      end
    end
    s_d.ep = s_q.ef;
    if (s_q.warm != `BDIA_WARM_DONE) begin
      s_d.warm = s_q.warm + 2'h1;
    end
    // manual reset clears the flag, a new miss in the same cycle still sets it
    if (i_manual_reset) begin
      s_d.no_trig = 1'b0;
    end
    // end-of-cycle trigger watchdog, the timing system owes one per cycle
    if (ev_rise[`BDIA_EV_CYCLE_END]) begin
      s_d.eoc_seen = ev_rise[`BDIA_EV_EOC];
      if (!s_q.eoc_seen && !ev_rise[`BDIA_EV_EOC]) begin
        s_d.no_trig = 1'b1;
      end
    end else if (ev_rise[`BDIA_EV_EOC]) begin
      s_d.eoc_seen = 1'b1;
    end
    // resets
    if (i_manual_reset) begin
      clr = ~fault;
      s_d.acnt = 2'h0;
    end else if (ev_rise[`BDIA_EV_CYCLE_END] &&
                 (|(s_q.trip & en & crate_mask(`BDIA_AUTO_CRATE)))) begin
      if (s_q.acnt != `BDIA_AUTO_MAX) begin
        clr = ~fault & crate_mask(`BDIA_AUTO_CRATE);
        s_d.acnt = s_q.acnt + 2'h1;
      end
    end
    // latch wins over any clear
    s_d.trip = (s_q.trip & ~clr) | (fault & en);
    s_d.dis = ~en;
    s_d.summ = |(s_d.trip & en);
    s_d.c3 = |(s_d.trip & en & crate_mask(`BDIA_INJ_CRATE));
    s_d.inh = (s_q.inh & ~i_manual_reset) | s_d.summ;
    // injection pre-pulse, delayed 500 cycles when inhibited at its arrival
    s_d.pp = 1'b0;
    unique case (s_q.pst)
      bdia_pkg::BDIA_PP_IDLE: begin
        if (ev_rise[`BDIA_EV_PREPULSE]) begin
          if (s_q.inh) begin
            s_d.pst = bdia_pkg::BDIA_PP_DELAY;
            s_d.dcnt = DLY_LOAD;
          end else begin
            s_d.pp = 1'b1;
          end
        end
      end
      bdia_pkg::BDIA_PP_DELAY: begin
        if (s_q.dcnt == 10'h000) begin
          s_d.pp = 1'b1;
          s_d.pst = bdia_pkg::BDIA_PP_IDLE;
        end else begin
          s_d.dcnt = s_q.dcnt - 10'h001;
        end
      end
    endcase
    // kicker fire: emergency at once, programmed on the gap
    fire_any = (s_d.summ & ~s_q.summ) | prog_fire;
    s_d.kh = fire_any & (i_beam_energy_gev <= `BDIA_ENERGY_THR_GEV);
    s_d.kv = fire_any & (i_beam_energy_gev > `BDIA_ENERGY_THR_GEV);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s_q <= '0;
      // loop filters start at the healthy idle level
      s_q.l1 <= '1;
      s_q.l2 <= '1;
      s_q.l3 <= '1;
      s_q.lf <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_horizontal_dump_kicker = s_q.kh;
  assign o_vertical_dump_kicker = s_q.kv;
  assign o_emergency_dump = s_q.summ;
  assign o_injection_kicker_summary = s_q.summ;
  assign o_injection_inhibit = s_q.inh;
  assign o_inj_prepulse = s_q.pp;
  assign o_injector_extraction_stop = s_q.c3;
  assign o_beam_permit = ~s_q.summ & ~(|(s_q.dis & ~i_sw_cond_disabled));
  assign o_chan_ok = ~s_q.trip;
  assign o_chan_remote = ~i_expert_protect;
  assign o_chan_enabled = ~s_q.dis;
  assign o_chan_disabled = s_q.dis;
  assign o_no_trigger = s_q.no_trig;
  assign o_auto_count = s_q.acnt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_fault_latches: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    1'b1 |=> (($past(fault) & $past(en) & ~s_q.trip) == '0))
    else $error("enabled fault not latched");

  a_auto_limit_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ev_rise[`BDIA_EV_CYCLE_END] && s_q.acnt == `BDIA_AUTO_MAX && !i_manual_reset)
    |=> ((($past(s_q.trip) & ~s_q.trip) & crate_mask(`BDIA_AUTO_CRATE)) == '0))
    else $error("auto reset past its limit");

  a_auto_count_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_manual_reset |=> (s_q.acnt == 2'h0))
    else $error("manual reset left auto count");

  a_notrig_raise: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ev_rise[`BDIA_EV_CYCLE_END] && !s_q.eoc_seen && !ev_rise[`BDIA_EV_EOC]
     && !i_manual_reset) |=> s_q.no_trig ##1 !o_chan_ok[`BDIA_NOTRIG_IDX])
    else $error("missing end-of-cycle trigger not flagged");

  a_emerg_kick_now: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(o_emergency_dump) |-> (o_horizontal_dump_kicker || o_vertical_dump_kicker))
    else $error("emergency dump without immediate kick");

  a_absorber_pick: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_vertical_dump_kicker |-> ($past(i_beam_energy_gev) > `BDIA_ENERGY_THR_GEV)
    && !o_horizontal_dump_kicker)
    else $error("wrong absorber for energy");

  a_prepulse_delay: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (s_q.inh && ev_rise[`BDIA_EV_PREPULSE] && s_q.pst == bdia_pkg::BDIA_PP_IDLE)
    |=> !o_inj_prepulse [*8] ##[490:495] o_inj_prepulse)
    else $error("inhibited pre-pulse not delayed");

  a_prepulse_free: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!s_q.inh && ev_rise[`BDIA_EV_PREPULSE] && s_q.pst == bdia_pkg::BDIA_PP_IDLE)
    |=> o_inj_prepulse)
    else $error("free pre-pulse held back");

  a_inhibit_reset: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_manual_reset && ((fault & en) == '0)) |=> !o_injection_inhibit)
    else $error("reset left injection inhibited");

  a_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((s_q.trip & en) == '0) |=> !o_emergency_dump || $past((fault & en) != '0))
    else $error("disabled channel caused a dump");

  a_auto_count_step: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ev_rise[`BDIA_EV_CYCLE_END] && !i_manual_reset && s_q.acnt != `BDIA_AUTO_MAX
     && ((s_q.trip & en & crate_mask(`BDIA_AUTO_CRATE)) != '0))
    |=> (s_q.acnt == $past(s_q.acnt) + 2'h1))
    else $error("auto reset not counted");

  a_stop_with_dump: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_injector_extraction_stop |-> o_emergency_dump)
    else $error("extraction stop without dump summary");

  a_inhibit_follows: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_injection_kicker_summary |-> o_injection_inhibit)
    else $error("injection not inhibited under dump summary");
endmodule

// >>> tb/bdia_timing_model.sv
// timing system and revolution reference model
`timescale 1ns/1ps
module bdia_timing_model (
  input wire logic i_ref_clk,
  output logic o_eoc_trigger,
  output logic o_cycle_end,
  output logic o_dump_event,
  output logic o_rev_ref
);
  logic [2:0] pins = 3'h0;
  logic [3:0] rev_cnt = 4'h0;
  assign o_eoc_trigger = pins[0];
  assign o_cycle_end = pins[1];
  assign o_dump_event = pins[2];
  // revolution reference runs free, one gap mark every 16 cycles
  assign o_rev_ref = rev_cnt[3];
  always @(posedge i_ref_clk) begin
    #10 rev_cnt = rev_cnt + 4'h1;
  end
  // one timing event: held 6 cycles so the synchroniser sees it
  task automatic pulse(input int sel);
    @(posedge i_ref_clk);
    #10;
    pins[sel] = 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #10;
    pins[sel] = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #10;
  endtask
  // end-of-cycle trigger, then end of elementary cycle
  task automatic send_cycle(input bit with_eoc);
    if (with_eoc) begin
      pulse(0);
    end
    pulse(1);
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the beam dump interlock aggregator
`timescale 1ns/1ps
module testbench;
  localparam int NCH = 24;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NCH-1:0] loop_ok;
  logic pp_in;
  logic [9:0] energy;
  logic mrst;
  logic [NCH-1:0] op_dis;
  logic [NCH-1:0] protect;
  logic [NCH-1:0] sw_dis;
  logic eoc, cyc_end, dump_ev, rev;
  logic hk, vk, emg, ksum, inh, pp_out, xstop, permit, no_trig;
  logic [NCH-1:0] ok, remote, en, dis;
  logic [1:0] acnt;
  int errors = 0;
  int checked = 0;
  int hk_n = 0;
  int vk_n = 0;
  int ph = 0;
  int n, k0, p0, wsel;
  logic watch;
  always #50 clk = ~clk;
  // kick pulse counters and gap phase of the last horizontal kick
  always @(posedge clk) begin
    if (hk === 1'b1) begin
      hk_n++;
      ph = tm.rev_cnt;
    end
    if (vk === 1'b1) vk_n++;
  end
  assign watch = (wsel == 0) ? emg : pp_out;
  bdia_timing_model tm (.i_ref_clk(clk), .o_eoc_trigger(eoc), .o_cycle_end(cyc_end),
    .o_dump_event(dump_ev), .o_rev_ref(rev));
  bdia_top DUT (.i_ref_clk(clk), .i_reset(rst), .i_loop_ok(loop_ok), .i_eoc_trigger(eoc),
    .i_cycle_end(cyc_end), .i_dump_event(dump_ev), .i_inj_prepulse(pp_in), .i_rev_ref(rev),
    .i_beam_energy_gev(energy), .i_manual_reset(mrst), .i_op_disable(op_dis),
    .i_expert_protect(protect), .i_sw_cond_disabled(sw_dis),
    .o_horizontal_dump_kicker(hk), .o_vertical_dump_kicker(vk), .o_emergency_dump(emg),
    .o_injection_kicker_summary(ksum), .o_injection_inhibit(inh), .o_inj_prepulse(pp_out),
    .o_injector_extraction_stop(xstop), .o_beam_permit(permit), .o_chan_ok(ok),
    .o_chan_remote(remote), .o_chan_enabled(en), .o_chan_disabled(dis),
    .o_no_trigger(no_trig), .o_auto_count(acnt));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [NCH-1:0] got, input logic [NCH-1:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  task automatic wait_for(input int sel, input int lim);
    wsel = sel;
    n = 0;
    #1;
    while (watch !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (watch !== 1'b1) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      give_verdict();
    end else begin
      #9;
    end
  endtask
  task automatic man_reset;
    step(6);
    mrst = 1'b1;
    step(1);
    mrst = 1'b0;
    step(4);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    loop_ok = '1;
    pp_in = 1'b0;
    energy = 10'h064;
    mrst = 1'b0;
    op_dis = '0;
    protect = '0;
    sw_dis = '0;
    step(3);
    rst = 1'b0;
    step(10);
    chk(ok, '1);
    chk(en, '1);
    chk(remote, ~protect);
    chk({acnt, no_trig, emg, inh, permit}, 6'h01);
    tm.send_cycle(1'b1);
    chk(no_trig, 1'b0);
    // client loss at the energy threshold
    k0 = hk_n;
    loop_ok[0] = 1'b0;
    wait_for(0, 12);
    chk({ok[0], ksum, inh}, 3'h3);
    step(2);
    chk_cnt(hk_n - k0, 1, 1);
    pp_in = 1'b1;
    wait_for(1, 600);
    pp_in = 1'b0;
    chk_cnt(n, 495, 515);
    loop_ok[0] = 1'b1;
    step(6);
    chk(ok[0], 1'b0);
    man_reset();
    chk({emg, inh, ok[0]}, 3'h1);
    pp_in = 1'b1;
    wait_for(1, 12);
    pp_in = 1'b0;
    chk_cnt(n, 1, 12);
    // crate 3 loss above the threshold
    energy = 10'h065;
    k0 = vk_n;
    loop_ok[17] = 1'b0;
    wait_for(0, 12);
    step(2);
    chk(xstop, 1'b1);
    chk_cnt(vk_n - k0, 1, 1);
    loop_ok[17] = 1'b1;
    man_reset();
    chk({xstop, inh}, 2'h0);
    energy = 10'h064;
    // operator disable, software condition, expert protection
    op_dis[10] = 1'b1;
    step(2);
    chk({dis[10], en[10], permit}, 3'h4);
    chk(dis, 24'h000400);
    loop_ok[10] = 1'b0;
    step(20);
    chk(emg, 1'b0);
    sw_dis[10] = 1'b1;
    step(1);
    chk(permit, 1'b1);
    op_dis[11] = 1'b1;
    protect[11] = 1'b1;
    step(2);
    chk({remote[11], en[11]}, 2'h1);
    loop_ok[11] = 1'b0;
    wait_for(0, 12);
    loop_ok = '1;
    op_dis = '0;
    protect = '0;
    sw_dis = '0;
    man_reset();
    // automatic reset of crate 2
    loop_ok[8] = 1'b0;
    wait_for(0, 12);
    loop_ok[8] = 1'b1;
    step(6);
    tm.send_cycle(1'b1);
    chk({acnt, ok[8]}, 3'h3);
    loop_ok[9] = 1'b0;
    wait_for(0, 12);
    for (int c = 2; c <= 3; c++) begin
      tm.send_cycle(1'b1);
      chk({acnt, ok[9]}, {c[1:0], 1'b0});
    end
    loop_ok[9] = 1'b1;
    step(6);
    tm.send_cycle(1'b1);
    chk({acnt, ok[9]}, 3'h6);
    man_reset();
    chk({acnt, ok[9]}, 3'h1);
    // missing end-of-cycle trigger
    tm.send_cycle(1'b0);
    step(2);
    chk({no_trig, ok[1], emg}, 3'h5);
    man_reset();
    chk({no_trig, emg}, 2'h0);
    // programmed dumps armed at different phases
    k0 = hk_n;
    tm.pulse(2);
    step(40);
    p0 = ph;
    step(3);
    tm.pulse(2);
    step(40);
    chk_cnt(hk_n - k0, 2, 2);
    chk_cnt(ph, p0, p0);
    give_verdict();
  end
endmodule
